// >>> hw/wdt_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Action select 0: each overflow pulses the interrupt request; counting goes on.
// - The interrupt request is never gated by any interrupt enable.
// - Every new event pulses the request again, even if one is in service.
// - Action select 1: overflow pulses the device reset request instead.
// - Writing clear code 0x4E zeroes the counter; counting continues.
// - Disable code 0xB1 stops the watchdog only while enable bit is 0.
// - Clear and overflow in one cycle: clear wins, no overflow.
// - Counter monitor output shows the live 8-bit count.
// - Running status bit is 1 while enabled, 0 while disabled.
// - Overflow cause flag sets when an overflow raises an interrupt.
// - Early-service flag sets when an out-of-window clear raises an interrupt.
// - A status read clears both cause flags.
// - A set coinciding with a status read wins over the clear.
// - Enable bit is 1 after reset release, so the watchdog runs.
// - Disabling zeroes the counter; setting enable again restarts with no code.
// - Window 00 allows clears anytime; otherwise early clears interrupt, no clear.
// - Counter pauses in stop, warm-up, idle and sleep; resumes afterwards.
module wdt_core
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ctrl_wr,
  input wire wdt_pkg::wdt_ctrl_s i_ctrl_wdata,
  input wire logic i_code_wr,
  input wire logic [7:0] i_code,
  input wire logic i_status_rd,
  input wire logic i_low_power,
  output wdt_pkg::wdt_ctrl_s o_ctrl,
  output logic [7:0] o_count,
  output wdt_pkg::wdt_status_s o_status,
  output logic o_nmi_req,
  output logic o_rst_req
);
  import wdt_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  wdt_ctrl_s ctrl_ff;
  wdt_ctrl_s nxt_ctrl;
  wdt_run_e run_ff;
  wdt_run_e nxt_run;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  wdt_status_s status_ff;
  wdt_status_s nxt_status;
  logic nmi_ff;
  logic nxt_nmi;
  logic rstreq_ff;
  logic nxt_rstreq;
  logic tick;
  logic in_window;
  logic clear_req;
  logic clear_ok;
  logic early_clear;
  logic disable_req;
  logic overflow;
  logic [7:0] win_lo;

  // Reset is released through two flops so removal is synchronous
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wdt_tick_gen u_tick
  (
    .i_clk(i_clk),
    .i_rst_b(rst_sync_ff),
    .i_run(run_ff == WDT_ON),
    .i_pause(i_low_power),
    .i_period(ctrl_ff.overflow_period_field),
    .o_tick(tick)
  );

  always_comb
  begin
    case (ctrl_ff.clear_window_field)
      WDT_WIN_ANY: win_lo = WDT_CNT_ZERO;
      WDT_WIN_1: win_lo = WDT_WIN_Q1;
      WDT_WIN_2: win_lo = WDT_WIN_HALF;
      default: win_lo = WDT_WIN_Q3;
    endcase
    in_window = (cnt_ff >= win_lo);
    clear_req = i_code_wr && (i_code == WDT_CODE_CLEAR) && (run_ff == WDT_ON);
    clear_ok = clear_req && in_window;
    early_clear = clear_req && !in_window;
    disable_req = i_code_wr && (i_code == WDT_CODE_DISABLE) && !ctrl_ff.watchdog_enable_bit;
    // Clear and disable both beat a coincident wrap
    overflow = (run_ff == WDT_ON) && tick && (cnt_ff == WDT_CNT_MAX) && !clear_ok
      && !disable_req;
  end

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_run = run_ff;
    if (i_ctrl_wr)
    begin
      nxt_ctrl = i_ctrl_wdata;
      if (i_ctrl_wdata.watchdog_enable_bit)
      begin
        nxt_run = WDT_ON;
      end
    end
    if (disable_req)
    begin
      nxt_run = WDT_OFF;
    end
  end

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (run_ff == WDT_OFF || disable_req)
    begin
      nxt_cnt = WDT_CNT_ZERO;
    end
    else if (clear_ok)
    begin
      nxt_cnt = WDT_CNT_ZERO;
    end
    else if (tick)
    begin
      nxt_cnt = cnt_ff + WDT_CNT_ONE;
    end
  end

  always_comb
  begin
    nxt_nmi = early_clear || (overflow && !ctrl_ff.overflow_action_select);
    nxt_rstreq = overflow && ctrl_ff.overflow_action_select;
    nxt_status.running_status_bit = (nxt_run == WDT_ON);
    // Set terms are ORed after the read clear so a coincident event survives
    nxt_status.overflow_cause_flag = (status_ff.overflow_cause_flag && !i_status_rd)
      || (overflow && !ctrl_ff.overflow_action_select);
    nxt_status.early_service_cause_flag = (status_ff.early_service_cause_flag
      && !i_status_rd) || early_clear;
  end

  always_ff @(posedge i_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      ctrl_ff <= '{WDT_RST_ENABLE, WDT_RST_ACTION, WDT_RST_WINDOW, WDT_RST_PERIOD};
      run_ff <= WDT_ON;
      cnt_ff <= WDT_CNT_ZERO;
      status_ff <= '{1'b0, 1'b0, 1'b1};
      nmi_ff <= 1'b0;
      rstreq_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      run_ff <= nxt_run;
      cnt_ff <= nxt_cnt;
      status_ff <= nxt_status;
      nmi_ff <= nxt_nmi;
      rstreq_ff <= nxt_rstreq;
    end
  end

  assign o_ctrl = ctrl_ff;
  assign o_count = cnt_ff;
  assign o_status = status_ff;
  assign o_nmi_req = nmi_ff;
  assign o_rst_req = rstreq_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_sync_ff);

  property p_ovf_nmi;
    overflow && !ctrl_ff.overflow_action_select |=> o_nmi_req && o_status.overflow_cause_flag;
  endproperty
  a_ovf_nmi: assert property (p_ovf_nmi) else $error("overflow did not raise nmi");

  property p_ovf_keeps_counting;
    overflow && !ctrl_ff.overflow_action_select |=> o_count == WDT_CNT_ZERO && run_ff == WDT_ON;
  endproperty
  a_ovf_keeps_counting: assert property (p_ovf_keeps_counting) else $error("counter stopped");

  property p_ovf_reset;
    overflow && ctrl_ff.overflow_action_select |=> o_rst_req && !o_nmi_req;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow did not request reset");

  property p_clear;
    clear_ok && !i_ctrl_wr |=> o_count == WDT_CNT_ZERO && !o_rst_req;
  endproperty
  a_clear: assert property (p_clear) else $error("clear code did not zero counter");

  property p_disable_guard;
    i_code_wr && i_code == WDT_CODE_DISABLE && ctrl_ff.watchdog_enable_bit && run_ff == WDT_ON
      && !i_ctrl_wr |=> run_ff == WDT_ON;
  endproperty
  a_disable_guard: assert property (p_disable_guard) else $error("disabled while enabled");

  property p_running_status;
    ##1 o_status.running_status_bit == (run_ff == WDT_ON);
  endproperty
  a_running_status: assert property (p_running_status) else $error("running status wrong");

  property p_early;
    // Early clear must leave the count alone; only a coincident tick may move it
    early_clear |=> o_nmi_req && o_status.early_service_cause_flag
      && (o_count == $past(o_count) + $past({7'h00, tick}));
  endproperty
  a_early: assert property (p_early) else $error("early clear not flagged");

  property p_read_clear;
    i_status_rd && !overflow && !early_clear |=> !o_status.overflow_cause_flag
      && !o_status.early_service_cause_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  property p_read_set_wins;
    i_status_rd && early_clear |=> o_status.early_service_cause_flag;
  endproperty
  a_read_set_wins: assert property (p_read_set_wins) else $error("set lost to read");

  property p_pause;
    i_low_power && run_ff == WDT_ON && !i_code_wr && !i_ctrl_wr |=> $stable(o_count);
  endproperty
  a_pause: assert property (p_pause) else $error("counter moved while paused");

  property p_off_zero;
    (run_ff == WDT_OFF && !i_ctrl_wr) [*2] |-> o_count == WDT_CNT_ZERO;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("counter not zero when off");

  c_ovf_nmi: cover property (overflow && !ctrl_ff.overflow_action_select);
  c_ovf_rst: cover property (overflow && ctrl_ff.overflow_action_select);
  c_early: cover property (early_clear);
  c_disable: cover property (disable_req);
endmodule

// >>> hw/wdt_pkg.sv
package wdt_pkg;
  localparam int unsigned WDT_CNT_W = 8;
  localparam logic [7:0] WDT_CODE_CLEAR = 8'h4E;
  localparam logic [7:0] WDT_CODE_DISABLE = 8'hB1;
  localparam logic [7:0] WDT_CNT_MAX = 8'hFF;
  localparam logic [7:0] WDT_CNT_ZERO = 8'h00;
  localparam logic [7:0] WDT_CNT_ONE = 8'h01;
  // Lower edge of the clear window for each window setting
  localparam logic [7:0] WDT_WIN_Q1 = 8'h40;
  localparam logic [7:0] WDT_WIN_HALF = 8'h80;
  localparam logic [7:0] WDT_WIN_Q3 = 8'hC0;
  localparam logic [1:0] WDT_WIN_ANY = 2'h0;
  localparam logic [1:0] WDT_WIN_1 = 2'h1;
  localparam logic [1:0] WDT_WIN_2 = 2'h2;
  // Source clock = 2**(WDT_SRC_LOG2 + 2*period) system clocks
  localparam int unsigned WDT_SRC_LOG2 = 8;
  localparam int unsigned WDT_DIV_W = WDT_SRC_LOG2 + 6;
  // Reset values of the control register
  localparam logic WDT_RST_ENABLE = 1'b1;
  localparam logic WDT_RST_ACTION = 1'b1;
  localparam logic [1:0] WDT_RST_WINDOW = 2'h0;
  localparam logic [1:0] WDT_RST_PERIOD = 2'h3;

  typedef enum logic {
    WDT_OFF = 1'b0,
    WDT_ON = 1'b1
  } wdt_run_e;

  typedef struct packed {
    logic watchdog_enable_bit;
    logic overflow_action_select;
    logic [1:0] clear_window_field;
    logic [1:0] overflow_period_field;
  } wdt_ctrl_s;

  typedef struct packed {
    logic overflow_cause_flag;
    logic early_service_cause_flag;
    logic running_status_bit;
  } wdt_status_s;
endpackage

// >>> hw/wdt_tick_gen.sv
`timescale 1ns/1ps
module wdt_tick_gen
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic i_pause,
  input wire logic [1:0] i_period,
  output logic o_tick
);
  import wdt_pkg::*;

  logic [WDT_DIV_W-1:0] div_ff;
  logic [WDT_DIV_W-1:0] nxt_div;
  logic [WDT_DIV_W-1:0] mask;

  always_comb
  begin
    mask = WDT_DIV_W'((1 << (WDT_SRC_LOG2 + 2 * int'(i_period))) - 1);
    o_tick = i_run && !i_pause && ((div_ff & mask) == mask);
    if (!i_run)
    begin
      nxt_div = '0;
    end
    else if (i_pause)
    begin
      nxt_div = div_ff;
    end
    else
    begin
      nxt_div = div_ff + WDT_DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div_ff <= '0;
    end
    else
    begin
      div_ff <= nxt_div;
    end
  end
endmodule

// >>> verification/tb_wdt_core.sv
`timescale 1ns/1ps
module tb_wdt_core;
  import wdt_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ctrl_wr = 1'b0;
  wdt_ctrl_s i_ctrl_wdata = '0;
  logic i_code_wr = 1'b0;
  logic [7:0] i_code = 8'h00;
  logic i_status_rd = 1'b0;
  logic i_low_power = 1'b0;
  wdt_ctrl_s o_ctrl;
  logic [7:0] o_count;
  wdt_status_s o_status;
  logic o_nmi_req;
  logic o_rst_req;
  logic [7:0] depth;
  logic [7:0] rst_cnt;
  logic [7:0] exp_depth = 8'h00;
  logic [7:0] snap;
  int err_total = 0;
  int num_checks = 0;

  always #2 i_clk = ~i_clk;

  wdt_core u_wdt_core
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ctrl_wr(i_ctrl_wr),
    .i_ctrl_wdata(i_ctrl_wdata),
    .i_code_wr(i_code_wr),
    .i_code(i_code),
    .i_status_rd(i_status_rd),
    .i_low_power(i_low_power),
    .o_ctrl(o_ctrl),
    .o_count(o_count),
    .o_status(o_status),
    .o_nmi_req(o_nmi_req),
    .o_rst_req(o_rst_req)
  );

  wdt_host_model u_wdt_host_model
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_global_interrupt_master_enable(1'b0),
    .i_nmi_req(o_nmi_req),
    .i_rst_req(o_rst_req),
    .o_nmi_depth(depth),
    .o_rst_count(rst_cnt)
  );

  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic ctrl_wr(input logic [5:0] v);
    i_ctrl_wdata = v;
    i_ctrl_wr = 1'b1;
    tick(1);
    i_ctrl_wr = 1'b0;
  endtask

  task automatic code_wr(input logic [7:0] c);
    i_code = c;
    i_code_wr = 1'b1;
    tick(1);
    i_code_wr = 1'b0;
  endtask

  task automatic t_clear;
    chk_byte("ctrl", 8'h33, {2'h0, o_ctrl});
    chk_byte("status", 8'h01, {5'h00, o_status});
    ctrl_wr(6'h20);
    tick(600);
    chk_bit("counting", 1'b1, o_count != 8'h00);
    code_wr(8'h4E);
    chk_byte("cleared", 8'h00, o_count);
    chk_bit("no_nmi", 1'b0, o_nmi_req);
  endtask

  task automatic t_early;
    ctrl_wr(6'h24);
    tick(600);
    snap = o_count;
    i_code = 8'h4E;
    i_code_wr = 1'b1;
    tick(1);
    chk_bit("nmi1", 1'b1, o_nmi_req);
    chk_bit("early", 1'b1, o_status.early_service_cause_flag);
    tick(1);
    i_code_wr = 1'b0;
    chk_bit("nmi2", 1'b1, o_nmi_req);
    chk_bit("kept", 1'b1, o_count >= snap && snap != 8'h00);
    i_status_rd = 1'b1;
    tick(1);
    i_status_rd = 1'b0;
    chk_byte("rdclr", 8'h01, {5'h00, o_status});
    tick(1);
    i_status_rd = 1'b1;
    i_code_wr = 1'b1;
    tick(1);
    i_status_rd = 1'b0;
    i_code_wr = 1'b0;
    chk_bit("setwins", 1'b1, o_status.early_service_cause_flag);
    exp_depth = exp_depth + 8'h03;
    tick(2);
    chk_byte("depth", exp_depth, depth);
    // Count is still far below 0x80, so both narrower windows refuse the clear
    ctrl_wr(6'h28);
    code_wr(8'h4E);
    chk_bit("win2", 1'b1, o_nmi_req);
    ctrl_wr(6'h2C);
    code_wr(8'h4E);
    chk_bit("win3", 1'b1, o_nmi_req);
    exp_depth = exp_depth + 8'h02;
  endtask

  task automatic t_pause;
    i_low_power = 1'b1;
    tick(2);
    snap = o_count;
    tick(1000);
    chk_byte("paused", snap, o_count);
    i_low_power = 1'b0;
    tick(600);
    chk_bit("resumed", 1'b1, o_count != snap);
  endtask

  task automatic t_disable;
    code_wr(8'hB1);
    chk_bit("run1", 1'b1, o_status.running_status_bit);
    ctrl_wr(6'h04);
    chk_bit("run2", 1'b1, o_status.running_status_bit);
    code_wr(8'hB1);
    chk_bit("run3", 1'b0, o_status.running_status_bit);
    tick(600);
    chk_byte("zero", 8'h00, o_count);
    ctrl_wr(6'h20);
    chk_bit("run4", 1'b1, o_status.running_status_bit);
  endtask

  task automatic t_overflow;
    int n;
    code_wr(8'h4E);
    for (n = 0; n < 66000 && o_nmi_req !== 1'b1; n++)
      tick(1);
    exp_depth = exp_depth + 8'h01;
    chk_bit("ovf_nmi", 1'b1, o_nmi_req);
    chk_byte("wrap", 8'h00, o_count);
    chk_bit("ovf_flag", 1'b1, o_status.overflow_cause_flag);
    chk_bit("no_rst", 1'b0, o_rst_req);
    tick(1);
    chk_bit("pulse", 1'b0, o_nmi_req);
    tick(300);
    chk_byte("goes_on", 8'h01, o_count);
    chk_byte("depth2", exp_depth, depth);
    chk_byte("rsts", 8'h00, rst_cnt);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(4 * 85000);
    err_total++;
    results;
  end

  initial
  begin
    tick(12);
    i_rst_b = 1'b1;
    tick(3);
    t_clear;
    t_early;
    t_pause;
    t_disable;
    t_overflow;
    results;
  end
endmodule

// >>> verification/wdt_host_model.sv
`timescale 1ns/1ps
module wdt_host_model
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_global_interrupt_master_enable,
  input wire logic i_nmi_req,
  input wire logic i_rst_req,
  output logic [7:0] o_nmi_depth,
  output logic [7:0] o_rst_count
);
  // Mask enable is ignored on purpose: the request cannot be masked
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_nmi_depth <= 8'h00;
      o_rst_count <= 8'h00;
    end
    else
    begin
      // No return is modelled, so nesting only grows
      if (i_nmi_req)
        o_nmi_depth <= o_nmi_depth + 8'h01;
      if (i_rst_req)
        o_rst_count <= o_rst_count + 8'h01;
    end
  end
endmodule
